// >>> logic/async_host_pio_port.sv
`timescale 1ns/1ps
// host parallel port: pins on one side, register strobes on the other
module async_host_pio_port (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              bus_style_select,
  input  wire logic                              chip_select_n,
  input  wire logic                              addr_latch_strobe,
  input  wire logic                              read_or_data_strobe,
  input  wire logic                              write_strobe_or_direction,
  input  wire logic [pio_port_pkg::ADDR_W-1:0]   addr_pin,
  input  wire logic [pio_port_pkg::DATA_W-1:0]   data_pin_in,
  output logic      [pio_port_pkg::DATA_W-1:0]   data_pin_out,
  output logic                                   data_pin_oe_n,
  output logic                                   transfer_ack_out,
  output logic      [pio_port_pkg::ADDR_W-1:0]   reg_addr,
  output logic                                   reg_rd_en,
  input  wire logic [pio_port_pkg::DATA_W-1:0]   reg_rd_data,
  output logic                                   reg_wr_en,
  output logic      [pio_port_pkg::DATA_W-1:0]   reg_wr_data
);

  // synchronised pin picture
  logic [pio_port_pkg::SYNC_W-1:0] sync_in;     // raw pins in sync order
  logic [pio_port_pkg::SYNC_W-1:0] sync_out;    // filtered pins
  logic                            style_s;     // high: data-strobe style
  logic                            cs_n_s;      // chip select, active low
  logic                            ale_s;       // address latch strobe
  logic                            rd_s;        // read strobe or data strobe
  logic                            wr_s;        // write strobe or direction
  logic [pio_port_pkg::ADDR_W-1:0] addr_s;      // address, same delay as strobes
  logic [pio_port_pkg::DATA_W-1:0] din_s;       // write data, same delay

  // previous strobe levels for edge detection
  logic ale_p_d, ale_p_q;
  logic rd_p_d,  rd_p_q;
  logic wr_p_d,  wr_p_q;
  logic ale_fall, ale_rise, rd_fall, rd_rise, wr_fall, wr_rise;
  logic selected;                               // chip select seen low

  // sequencer state
  pio_port_pkg::pio_state_t        state_d, state_q;
  logic                            mode_d, mode_q;        // style held for the access
  logic [pio_port_pkg::ADDR_W-1:0] addr_d, addr_q;        // latched address
  logic [pio_port_pkg::DATA_W-1:0] dout_d, dout_q;        // read data on the pins
  logic                            oe_n_d, oe_n_q;        // data bus drive, low drives
  logic                            ack_d, ack_q;          // ready / acknowledge pin
  logic                            rd_en_d, rd_en_q;      // read side-effect pulse
  logic                            wr_en_d, wr_en_q;      // write commit pulse
  logic [pio_port_pkg::DATA_W-1:0] wdat_d, wdat_q;        // committed byte
  logic                            settle_start;          // starts the settle timer
  logic                            settle_done;           // settle time over

  // address and data travel the same chain as the strobes so they stay aligned
  assign sync_in = {bus_style_select, chip_select_n, addr_latch_strobe,
                    read_or_data_strobe, write_strobe_or_direction, addr_pin, data_pin_in};

  pin_sync u_sync (
    .clk     (clk),
    .rst     (rst),
    .pin_in  (sync_in),
    .pin_out (sync_out)
  );

  // unpack the filtered picture
  assign style_s = sync_out[pio_port_pkg::POS_STY];
  assign cs_n_s  = sync_out[pio_port_pkg::POS_CS];
  assign ale_s   = sync_out[pio_port_pkg::POS_ALE];
  assign rd_s    = sync_out[pio_port_pkg::POS_RD];
  assign wr_s    = sync_out[pio_port_pkg::POS_WR];
  assign addr_s  = sync_out[pio_port_pkg::POS_ADDR +: pio_port_pkg::ADDR_W];
  assign din_s   = sync_out[pio_port_pkg::POS_DATA +: pio_port_pkg::DATA_W];

  // edges only from synchronised levels
  assign ale_fall = ale_p_q & ~ale_s;
  assign ale_rise = ~ale_p_q & ale_s;
  assign rd_fall  = rd_p_q & ~rd_s;
  assign rd_rise  = ~rd_p_q & rd_s;
  assign wr_fall  = wr_p_q & ~wr_s;
  assign wr_rise  = ~wr_p_q & wr_s;
  assign selected = ~cs_n_s;

  settle_timer u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (settle_start),
    .done  (settle_done)
  );

  // next-state logic; one access at a time, no burst
  always_comb begin
    state_d      = state_q;
    mode_d       = mode_q;
    addr_d       = addr_q;
    dout_d       = dout_q;
    wdat_d       = wdat_q;
    rd_en_d      = 1'b0;
    wr_en_d      = 1'b0;
    settle_start = 1'b0;
    ale_p_d      = ale_s;
    rd_p_d       = rd_s;
    wr_p_d       = wr_s;
    // address latch works in any state so a new address can follow at once
    if (selected && !style_s && ale_fall) begin
      addr_d = addr_s;
    end else if (selected && style_s && ale_rise) begin
      addr_d = addr_s;
    end
    case (state_q)
      pio_port_pkg::ST_IDLE: begin
        mode_d = style_s;
        if (selected && !style_s && rd_fall) begin
          // separate style read: drive bus, hold ready low
          state_d      = pio_port_pkg::ST_RD_SETTLE;
          rd_en_d      = 1'b1;
          settle_start = 1'b1;
        end else if (selected && !style_s && wr_fall) begin
          state_d = pio_port_pkg::ST_WR_HOLD;
        end else if (selected && style_s && rd_fall && wr_s) begin
          state_d      = pio_port_pkg::ST_RD_SETTLE;
          rd_en_d      = 1'b1;
          settle_start = 1'b1;
        end else if (selected && style_s && rd_fall && !wr_s) begin
          state_d      = pio_port_pkg::ST_WR_SETTLE;
          settle_start = 1'b1;
        end
      end
      pio_port_pkg::ST_RD_SETTLE: begin
        if (rd_rise) begin
          // host gave up early: just release the bus
          state_d = pio_port_pkg::ST_IDLE;
        end else if (settle_done) begin
          dout_d  = reg_rd_data;
          state_d = pio_port_pkg::ST_RD_VALID;
        end
      end
      pio_port_pkg::ST_RD_VALID: begin
        // host waits for ready or acknowledge before this edge
        if (rd_rise) begin
          state_d = pio_port_pkg::ST_IDLE;
        end
      end
      pio_port_pkg::ST_WR_HOLD: begin
        if (wr_rise) begin
          wdat_d  = din_s;
          wr_en_d = 1'b1;
          state_d = pio_port_pkg::ST_IDLE;
        end
      end
      pio_port_pkg::ST_WR_SETTLE: begin
        if (rd_rise) begin
          // strobe ended before acknowledge: still take the byte
          wdat_d  = din_s;
          wr_en_d = 1'b1;
          state_d = pio_port_pkg::ST_IDLE;
        end else if (settle_done) begin
          state_d = pio_port_pkg::ST_WR_ACK;
        end
      end
      pio_port_pkg::ST_WR_ACK: begin
        if (rd_rise) begin
          wdat_d  = din_s;
          wr_en_d = 1'b1;
          state_d = pio_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = pio_port_pkg::ST_IDLE;
      end
    endcase
    // pin drive follows the next state so pins and state change together
    oe_n_d = !((state_d == pio_port_pkg::ST_RD_SETTLE) ||
               (state_d == pio_port_pkg::ST_RD_VALID));
    if (mode_d) begin
      // data-strobe style: acknowledge is active low
      ack_d = !((state_d == pio_port_pkg::ST_RD_VALID) ||
                (state_d == pio_port_pkg::ST_WR_ACK));
    end else begin
      // separate style: ready low means not yet valid
      ack_d = (state_d != pio_port_pkg::ST_RD_SETTLE);
    end
  end

  // registers only
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= pio_port_pkg::ST_IDLE;
      mode_q  <= pio_port_pkg::STYLE_SEP;
      addr_q  <= pio_port_pkg::ADDR_RESET;
      dout_q  <= pio_port_pkg::DATA_RESET;
      wdat_q  <= pio_port_pkg::DATA_RESET;
      oe_n_q  <= 1'b1;
      ack_q   <= pio_port_pkg::ACK_IDLE;
      rd_en_q <= 1'b0;
      wr_en_q <= 1'b0;
      // previous levels match the synchroniser's reset picture, so no false edge follows reset
      ale_p_q <= pio_port_pkg::SYNC_RESET[pio_port_pkg::POS_ALE];
      rd_p_q  <= pio_port_pkg::SYNC_RESET[pio_port_pkg::POS_RD];
      wr_p_q  <= pio_port_pkg::SYNC_RESET[pio_port_pkg::POS_WR];
    end else begin
      state_q <= state_d;
      mode_q  <= mode_d;
      addr_q  <= addr_d;
      dout_q  <= dout_d;
      wdat_q  <= wdat_d;
      oe_n_q  <= oe_n_d;
      ack_q   <= ack_d;
      rd_en_q <= rd_en_d;
      wr_en_q <= wr_en_d;
      ale_p_q <= ale_p_d;
      rd_p_q  <= rd_p_d;
      wr_p_q  <= wr_p_d;
    end
  end

  // all outputs straight from flip-flops
  assign data_pin_out     = dout_q;
  assign data_pin_oe_n    = oe_n_q;
  assign transfer_ack_out = ack_q;
  assign reg_addr         = addr_q;
  assign reg_rd_en        = rd_en_q;
  assign reg_wr_en        = wr_en_q;
  assign reg_wr_data      = wdat_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sep_addr_latch_a: assert property (
    (selected && !style_s && ale_fall) |=> (reg_addr == $past(addr_s)))
    else $error("address not latched on latch strobe fall");

  ds_addr_latch_a: assert property (
    (selected && style_s && ale_rise) |=> (reg_addr == $past(addr_s)))
    else $error("address not latched on address strobe rise");

  sep_read_start_a: assert property (
    (state_q == pio_port_pkg::ST_IDLE && selected && !style_s && rd_fall)
      |=> (!data_pin_oe_n && !transfer_ack_out && reg_rd_en))
    else $error("read start did not drive bus and drop ready");

  sep_ready_rise_a: assert property (
    (state_q == pio_port_pkg::ST_RD_SETTLE && !mode_q && !rd_rise)
      |-> ##[1:4] (transfer_ack_out || state_q == pio_port_pkg::ST_IDLE))
    else $error("ready did not return high after settle");

  ready_data_a: assert property (
    $rose(state_q == pio_port_pkg::ST_RD_VALID) |-> (data_pin_out == $past(reg_rd_data)))
    else $error("data on bus is not the read value");

  bus_release_a: assert property (
    (state_q == pio_port_pkg::ST_RD_VALID && rd_rise) |=> data_pin_oe_n [*2])
    else $error("bus not released after read strobe rise");

  sep_write_commit_a: assert property (
    (state_q == pio_port_pkg::ST_WR_HOLD && wr_rise)
      |=> (reg_wr_en && reg_wr_data == $past(din_s)) ##1 !reg_wr_en)
    else $error("write byte not committed on strobe rise");

  ds_read_ack_a: assert property (
    (state_q == pio_port_pkg::ST_RD_VALID && mode_q) |-> (!transfer_ack_out && !data_pin_oe_n))
    else $error("acknowledge missing while read data valid");

  ds_write_ack_a: assert property (
    (state_q == pio_port_pkg::ST_WR_SETTLE && !rd_rise && !settle_done) |=>
      (transfer_ack_out || state_q == pio_port_pkg::ST_WR_ACK))
    else $error("acknowledge raised before write data settled");

  single_access_a: assert property (
    reg_rd_en |-> (!reg_wr_en ##1 !reg_rd_en))
    else $error("read strobe longer than one cycle");

  // data-strobe read start: bus driven, acknowledge still high
  ds_read_start_a: assert property (
    (state_q == pio_port_pkg::ST_IDLE && selected && style_s && rd_fall && wr_s)
      |=> (!data_pin_oe_n && transfer_ack_out && reg_rd_en))
    else $error("data-strobe read start wrong");

  // data-strobe write: byte taken on strobe rise, acknowledge withdrawn
  ds_write_commit_a: assert property (
    (state_q == pio_port_pkg::ST_WR_ACK && rd_rise)
      |=> (reg_wr_en && reg_wr_data == $past(din_s) && transfer_ack_out))
    else $error("data-strobe write byte not committed");

  // ready is only a read signal; a separate-style write keeps it high
  sep_write_ready_a: assert property (
    (state_q == pio_port_pkg::ST_WR_HOLD) |-> transfer_ack_out)
    else $error("ready dropped during write");

  // nothing starts while chip select is high
  deselect_ignore_a: assert property (
    (state_q == pio_port_pkg::ST_IDLE && !selected) |=> (!reg_rd_en && !reg_wr_en))
    else $error("access started while deselected");

  // an idle port neither drives the bus nor holds the answer pin low
  idle_quiet_a: assert property (
    (state_q == pio_port_pkg::ST_IDLE) |-> (data_pin_oe_n && transfer_ack_out))
    else $error("idle port drives bus or answer pin");

  cov_sep_read: cover property (
    (state_q == pio_port_pkg::ST_RD_VALID && !mode_q) ##[1:20] (state_q == pio_port_pkg::ST_IDLE));
  cov_sep_write: cover property (state_q == pio_port_pkg::ST_WR_HOLD ##[1:20] reg_wr_en);
  cov_ds_read: cover property (state_q == pio_port_pkg::ST_RD_VALID && mode_q);
  cov_ds_write: cover property (state_q == pio_port_pkg::ST_WR_ACK ##[1:20] reg_wr_en);

endmodule

// >>> logic/pio_port_pkg.sv
package pio_port_pkg;

  // bus widths
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;

  // settle time that the host sees between strobe and valid data
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS     = 20;
  // least time: round up, never under one cycle
  localparam int SETTLE_RAW    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
  localparam int TIMER_W       = 4;
  localparam logic [TIMER_W-1:0] SETTLE_COUNT = TIMER_W'(SETTLE_CYCLES);
  localparam logic [TIMER_W-1:0] TIMER_RESET  = 4'h0;

  // synchroniser layout: style, cs_n, latch, read/ds, write/dir, addr, data
  localparam int SYNC_W   = 5 + ADDR_W + DATA_W;
  localparam int POS_DATA = 0;
  localparam int POS_ADDR = DATA_W;
  localparam int POS_WR   = DATA_W + ADDR_W;
  localparam int POS_RD   = POS_WR + 1;
  localparam int POS_ALE  = POS_WR + 2;
  localparam int POS_CS   = POS_WR + 3;
  localparam int POS_STY  = POS_WR + 4;
  // idle pin levels: cs, read and write strobes high; latch and style low
  localparam logic [SYNC_W-1:0] SYNC_RESET = 28'h5800000;

  // values after reset
  localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic              ACK_IDLE   = 1'b1;
  localparam logic              STYLE_SEP  = 1'b0;

  // access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_RD_SETTLE = 3'b001,
    ST_RD_VALID  = 3'b010,
    ST_WR_HOLD   = 3'b011,
    ST_WR_SETTLE = 3'b100,
    ST_WR_ACK    = 3'b101
  } pio_state_t;

endpackage

// >>> logic/pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser with agreement filter per bit
module pin_sync (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic [pio_port_pkg::SYNC_W-1:0]   pin_in,
  output logic      [pio_port_pkg::SYNC_W-1:0]   pin_out
);

  logic [pio_port_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q;   // metastability chain
  logic [pio_port_pkg::SYNC_W-1:0] out_d, out_q;        // filtered level

  // a bit moves only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < pio_port_pkg::SYNC_W; i++) begin : g_bit
      always_comb begin
        out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
    end
  endgenerate

  // s1 feeds only s2
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q  <= pio_port_pkg::SYNC_RESET;
      s2_q  <= pio_port_pkg::SYNC_RESET;
      s3_q  <= pio_port_pkg::SYNC_RESET;
      out_q <= pio_port_pkg::SYNC_RESET;
    end else begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign pin_out = out_q;

endmodule

// >>> logic/settle_timer.sv
`timescale 1ns/1ps
// counts the data settle time; done pulses when it runs out
module settle_timer (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      done
);

  logic [pio_port_pkg::TIMER_W-1:0] count_d, count_q;   // cycles left

  // restart wins over a running count
  always_comb begin
    if (start) begin
      count_d = pio_port_pkg::SETTLE_COUNT;
    end else if (count_q != pio_port_pkg::TIMER_RESET) begin
      count_d = count_q - 4'h1;
    end else begin
      count_d = count_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= pio_port_pkg::TIMER_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  // a start in the last cycle cancels the pulse
  assign done = (count_q == 4'h1) && !start;

endmodule

// >>> bench/host_cpu_model.sv
`timescale 1ns/1ps
// behavioural host processor: drives the port pins in either strobe style
module host_cpu_model (
  input  wire logic                              clk,
  input  wire logic                              ack,
  input  wire logic [pio_port_pkg::DATA_W-1:0]   bus,
  output logic                                   style,
  output logic                                   cs_n,
  output logic                                   ale,
  output logic                                   rds,
  output logic                                   wrd,
  output logic      [pio_port_pkg::ADDR_W-1:0]   addr,
  output logic      [pio_port_pkg::DATA_W-1:0]   dout,
  output logic                                   doe
);
  // idle pins at time zero: deselected, read and write strobes high, latch low, bus not driven
  initial begin
    style = 1'b0;
    cs_n  = 1'b1;
    ale   = 1'b0;
    rds   = 1'b1;
    wrd   = 1'b1;
    addr  = 15'h0000;
    dout  = 8'h00;
    doe   = 1'b0;
  end

  // pins only move on the falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // bounded wait for the answer pin; a hang shows as hit low
  task automatic wait_ack(input logic lvl, output logic hit);
    int n;
    hit = 1'b0;
    for (n = 0; n < 40 && !hit; n++) begin
      // look at the falling edge, where the registered pin has settled
      @(negedge clk);
      hit = (ack === lvl);
    end
  endtask

  // address phase; sel low leaves the device deselected
  task automatic latch(input logic sty, input logic sel, input logic [pio_port_pkg::ADDR_W-1:0] a);
    style = sty;
    ale   = sty;                 // idle level of the latch strobe in this style
    cyc(2);
    addr  = a;
    cs_n  = !sel;
    ale   = !sty;
    cyc(3);
    ale   = sty;                 // fall or rise takes the address
    cyc(3);
    addr  = ~a;                  // pins move on so a stale copy is caught
  endtask

  // read cycle; slow stretches the time before the strobe is released
  task automatic read(input int slow, output logic [pio_port_pkg::DATA_W-1:0] d, output logic ok);
    logic lo;
    logic hi;
    @(negedge clk);
    wrd = 1'b1;                  // direction high marks a read
    cyc(1);
    rds = 1'b0;
    wait_ack(1'b0, lo);
    hi = 1'b1;
    if (!style) begin
      wait_ack(1'b1, hi);        // ready rises only once data is valid
    end
    d   = bus;
    ok  = lo && hi;
    cyc(1 + slow);
    rds = 1'b1;                  // released only after the answer
    cyc(8);
    cs_n = 1'b1;
  endtask

  // write cycle in the current style
  task automatic write(input int slow, input logic [pio_port_pkg::DATA_W-1:0] v, output logic ok);
    @(negedge clk);
    if (style) begin
      wrd  = 1'b0;               // direction low marks a write
      dout = v;
      doe  = 1'b1;
      cyc(2);
      rds  = 1'b0;
      wait_ack(1'b0, ok);
      cyc(1 + slow);
      rds  = 1'b1;               // byte latched on this rise
    end else begin
      wrd  = 1'b0;
      cyc(1);
      dout = v;                  // data follows the strobe
      doe  = 1'b1;
      cyc(3 + slow);
      ok   = (ack === 1'b1);     // ready stays high through a separate write
      wrd  = 1'b1;               // commit edge
    end
    cyc(2);
    doe  = 1'b0;                 // hold past the edge, then let go
    cyc(6);
    wrd  = 1'b1;
    cs_n = 1'b1;
  endtask
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
// self-checking bench: host model on the pins, small register file behind
module tb_top;
  logic                              clk;           // 100 MHz
  logic                              rst;           // synchronous, active high
  logic                              h_style;       // host pins
  logic                              h_cs_n;
  logic                              h_ale;
  logic                              h_rds;
  logic                              h_wrd;
  logic [pio_port_pkg::ADDR_W-1:0]   h_addr;
  logic [pio_port_pkg::DATA_W-1:0]   h_dout;
  logic                              h_doe;
  logic [pio_port_pkg::DATA_W-1:0]   data_bus;      // resolved data wire
  logic [pio_port_pkg::DATA_W-1:0]   bus_last;      // for the undriven pattern
  logic [pio_port_pkg::DATA_W-1:0]   data_pin_out;
  logic                              data_pin_oe_n;
  logic                              transfer_ack_out;
  logic [pio_port_pkg::ADDR_W-1:0]   reg_addr;
  logic                              reg_rd_en;
  logic [pio_port_pkg::DATA_W-1:0]   reg_rd_data;
  logic                              reg_wr_en;
  logic [pio_port_pkg::DATA_W-1:0]   reg_wr_data;
  logic [pio_port_pkg::DATA_W-1:0]   mem [4];       // register file, low address bits
  logic [pio_port_pkg::DATA_W-1:0]   exp_mem [4];   // what the bench expects there
  logic [pio_port_pkg::ADDR_W-1:0]   wr_addr_seen;
  logic [pio_port_pkg::DATA_W-1:0]   wr_data_seen;
  int                                errors;
  int                                checked;
  int                                cycles;
  int                                wr_cnt;
  int                                rd_cnt;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // undriven wire shows a changing pattern, never the last value
  assign data_bus    = (data_pin_oe_n === 1'b0) ? data_pin_out : (h_doe ? h_dout : ~bus_last);
  assign reg_rd_data = mem[reg_addr[1:0]];

  async_host_pio_port i_async_host_pio_port (
    .clk(clk), .rst(rst), .bus_style_select(h_style), .chip_select_n(h_cs_n),
    .addr_latch_strobe(h_ale), .read_or_data_strobe(h_rds), .write_strobe_or_direction(h_wrd),
    .addr_pin(h_addr), .data_pin_in(data_bus), .data_pin_out(data_pin_out),
    .data_pin_oe_n(data_pin_oe_n), .transfer_ack_out(transfer_ack_out), .reg_addr(reg_addr),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data)
  );

  host_cpu_model i_host_cpu_model (
    .clk(clk), .ack(transfer_ack_out), .bus(data_bus), .style(h_style), .cs_n(h_cs_n),
    .ale(h_ale), .rds(h_rds), .wrd(h_wrd), .addr(h_addr), .dout(h_dout), .doe(h_doe)
  );

  // register side: stores committed bytes and counts the strobes
  always @(posedge clk) begin
    bus_last <= data_bus;
    cycles++;
    if (reg_wr_en === 1'b1) begin
      wr_cnt++;
      wr_addr_seen = reg_addr;
      wr_data_seen = reg_wr_data;
      mem[reg_addr[1:0]] <= reg_wr_data;
    end
    if (reg_rd_en === 1'b1) begin
      rd_cnt++;
    end
    if (cycles >= 4000) begin    // hang guard, runs take about 340 cycles
      errors++;
      print_verdict();
    end
  end

  task automatic check_val(input string what, input logic [14:0] exp, input logic [14:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_cnt(input string what, input int exp, input int got);
    checked++;
    if (got != exp) begin
      errors++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // one write through the pins, judged at the register side
  task automatic do_write(input logic sty, input logic [14:0] a, input logic [7:0] v, input int slow);
    int   n0;
    logic ok;
    n0 = wr_cnt;
    i_host_cpu_model.latch(sty, 1'b1, a);
    i_host_cpu_model.write(slow, v, ok);
    check_val("write ack", 15'h0001, {14'h0000, ok});
    check_cnt("write pulses", n0 + 1, wr_cnt);
    check_val("write addr", a, wr_addr_seen);
    check_val("write data", {7'h00, v}, {7'h00, wr_data_seen});
    exp_mem[a[1:0]] = v;
  endtask

  // one read through the pins, judged at the pins
  task automatic do_read(input logic sty, input logic [14:0] a, input int slow);
    int         n0;
    logic       ok;
    logic [7:0] d;
    n0 = rd_cnt;
    i_host_cpu_model.latch(sty, 1'b1, a);
    i_host_cpu_model.read(slow, d, ok);
    check_val("read handshake", 15'h0001, {14'h0000, ok});
    check_val("read data", {7'h00, exp_mem[a[1:0]]}, {7'h00, d});
    check_cnt("read pulses", n0 + 1, rd_cnt);
    check_val("read addr", a, reg_addr);
    check_val("bus released", 15'h0001, {14'h0000, data_pin_oe_n});
    check_val("ack idle", 15'h0001, {14'h0000, transfer_ack_out});
  endtask

  // idle outputs straight after reset
  task automatic t_reset();
    check_val("oe idle", 15'h0001, {14'h0000, data_pin_oe_n});
    check_val("ack idle", 15'h0001, {14'h0000, transfer_ack_out});
    check_val("addr reset", 15'h0000, reg_addr);
  endtask

  // separate strobes: boundary addresses, back to back, two slow accesses
  task automatic t_sep();
    do_write(1'b0, 15'h7FFF, 8'hA5, 0);
    do_write(1'b0, 15'h0000, 8'h5A, 2);
    do_read(1'b0, 15'h7FFF, 0);
    do_read(1'b0, 15'h0000, 3);
  endtask

  // data strobe style, then crossing styles between accesses
  task automatic t_ds();
    do_write(1'b1, 15'h2AAA, 8'hC3, 0);
    do_read(1'b1, 15'h2AAA, 2);
    do_read(1'b1, 15'h7FFF, 0);
    do_write(1'b1, 15'h5555, 8'h3C, 3);
    do_read(1'b0, 15'h5555, 0);
  endtask

  // strobes while deselected must change nothing
  task automatic t_cs_off();
    int                              w0;
    int                              r0;
    logic [pio_port_pkg::ADDR_W-1:0] a0;
    logic                            ok;
    logic [7:0]                      d;
    w0 = wr_cnt;
    r0 = rd_cnt;
    a0 = reg_addr;
    i_host_cpu_model.latch(1'b0, 1'b0, 15'h1234);
    i_host_cpu_model.write(0, 8'hFF, ok);
    i_host_cpu_model.read(0, d, ok);
    check_cnt("ignored write", w0, wr_cnt);
    check_cnt("ignored read", r0, rd_cnt);
    check_val("kept addr", a0, reg_addr);
    do_read(1'b0, 15'h0000, 0);
  endtask

  task automatic print_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    errors   = 0;
    checked  = 0;
    cycles   = 0;
    wr_cnt   = 0;
    rd_cnt   = 0;
    bus_last = 8'h00;
    for (int i = 0; i < 4; i++) begin
      mem[i]     = 8'h00;
      exp_mem[i] = 8'h00;
    end
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_sep();
    t_ds();
    t_cs_off();
    print_verdict();
  end
endmodule
